// ===== core/phy_irq_cfg.svh
`ifndef PHY_IRQ_CFG_SVH
`define PHY_IRQ_CFG_SVH

// register numbers on the management interface
`define REG_BASIC_STATUS 5'h01
`define REG_AN_EXPANSION 5'h06
`define REG_MODE_CTRL 5'h11
`define REG_IRQ_FLAGS 5'h1D
`define REG_IRQ_MASK 5'h1E

// field positions
`define MODE_ALT_BIT 6
`define MODE_ENERGY_BIT 1
`define SRC_WAKE 8
`define SRC_ENERGY 7
`define SRC_AN_DONE 6
`define SRC_RFAULT 5
`define SRC_LINK_DOWN 4
`define SRC_LP_ACK 3
`define SRC_PDF 2
`define SRC_PAGE 1

// field groups
`define FLAG_BITS 16'h01FE
`define LINK_CLR_BITS 16'h0030
`define AN_CLR_BITS 16'h0006
`define FALL_CLR_BITS 16'h01EE

// reset values
`define FLAGS_RST 16'h0080
`define MASK_RST 16'h0000
`define COND_RST 16'h0090

// timing
`define CLK_PERIOD_NS 10
`define ED_DELAY_MS 1000
`define ED_PULSE_MS 256
`define ED_DELAY_CYC (`ED_DELAY_MS * 1000000 / `CLK_PERIOD_NS)
`define ED_PULSE_CYC (`ED_PULSE_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ===== core/phy_irq_pkg.sv
package phy_irq_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } reg_acc_t;

   typedef struct packed {
      logic [3:0] wake;
      logic energy_detect;
      logic an_done;
      logic rfault;
      logic link_up;
      logic lp_ack;
      logic pdf;
      logic page;
      logic an_restart;
   } phy_status_t;

   typedef enum logic [1:0] {
      ED_IDLE,
      ED_ARMED,
      ED_WAIT,
      ED_PULSE
   } ed_state_t;

   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] mask;
      logic alt;
      logic [15:0] prev;
      ed_state_t ed;
      logic [27:0] cnt;
      logic [15:0] rd_data;
      logic irq_n;
   } irq_state_t;

endpackage : phy_irq_pkg

// ===== core/phy_interrupt_manager.sv
`timescale 1ns/1ps
`include "phy_irq_cfg.svh"
// What this block does
// - after reset the block runs in primary mode, alternate select zero.
// - primary mode: enabled sources assert on an event, drop on its end; link down waits for a read.
// - mask and flag bits 8..1: wake energy an rfault linkdn ack pdf page.
// - wake sets on a rise of its or, clears when all low or on a flags read.
// - rfault follows its bit, link down sets on loss; both clear on reads.
// - pdf and page clear on fall, reg 6 or flags read, restart or link loss.
// - energy flag freed while high arms a 256 ms pulse 1 s after the fall.
// - the energy flag reads one at power-up and clears once energy drops.
// - a one written to the alternate select bit enters alternate mode.
// - alternate mode: clearing a mask bit releases that source's interrupt.
// - alt mode: writing one to a flag rechecks it; it clears only if quiet.
// - quiet means status low; link down needs link up, wake all four low.
// - the interrupt output is active low while an enabled event is pending.
module phy_interrupt_manager #(
   parameter int ED_DELAY_CYC = `ED_DELAY_CYC,
   parameter int ED_PULSE_CYC = `ED_PULSE_CYC
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire phy_irq_pkg::reg_acc_t reg_acc_i,
   input wire phy_irq_pkg::phy_status_t status_i,
   output logic [15:0] rd_data_o,
   output logic irq_out_n_o,
   output logic alt_irq_select_o
);

   phy_irq_pkg::irq_state_t st_r;
   phy_irq_pkg::irq_state_t st_nxt;
   logic [15:0] cond;
   logic [15:0] rise;
   logic [15:0] fall;
   logic [15:0] clr;
   logic rd_flags;
   logic wr_flags;

   // active-high view of each source; link down is the inverse of link up
   function automatic logic [15:0] cond_f(input phy_irq_pkg::phy_status_t s);
      logic [15:0] c;
      c = 16'h0000;
      c[`SRC_WAKE] = |s.wake;
      c[`SRC_ENERGY] = s.energy_detect;
      c[`SRC_AN_DONE] = s.an_done;
      c[`SRC_RFAULT] = s.rfault;
      c[`SRC_LINK_DOWN] = ~s.link_up;
      c[`SRC_LP_ACK] = s.lp_ack;
      c[`SRC_PDF] = s.pdf;
      c[`SRC_PAGE] = s.page;
      return c;
   endfunction : cond_f

   function automatic logic hit_f(input phy_irq_pkg::reg_acc_t a,
                                  input logic [4:0] addr);
      return a.addr == addr;
   endfunction : hit_f

   always_comb begin
      st_nxt = st_r;
      cond = cond_f(status_i);
      rise = cond & ~st_r.prev;
      fall = ~cond & st_r.prev;
      rd_flags = reg_acc_i.rd && hit_f(reg_acc_i, `REG_IRQ_FLAGS);
      wr_flags = reg_acc_i.wr && hit_f(reg_acc_i, `REG_IRQ_FLAGS);
      clr = 16'h0000;
      st_nxt.prev = cond;
      if (!st_r.alt) begin
         clr = fall & `FALL_CLR_BITS;
         if (rd_flags) begin
            clr = clr | `FLAG_BITS;
         end
         if (reg_acc_i.rd && hit_f(reg_acc_i, `REG_BASIC_STATUS)) begin
            clr = clr | `LINK_CLR_BITS;
         end
         if ((reg_acc_i.rd && hit_f(reg_acc_i, `REG_AN_EXPANSION)) ||
             status_i.an_restart || rise[`SRC_LINK_DOWN]) begin
            clr = clr | `AN_CLR_BITS;
         end
      end else if (wr_flags) begin
         // recheck: a flag only drops while its source is quiet
         clr = reg_acc_i.wdata & ~cond & `FLAG_BITS;
      end
      // a new event in the clearing cycle keeps the flag set
      st_nxt.flags = ((st_r.flags & ~clr) | rise) & `FLAG_BITS;
      if (reg_acc_i.wr && hit_f(reg_acc_i, `REG_IRQ_MASK)) begin
         st_nxt.mask = reg_acc_i.wdata & `FLAG_BITS;
      end
      if (reg_acc_i.wr && hit_f(reg_acc_i, `REG_MODE_CTRL)) begin
         st_nxt.alt = reg_acc_i.wdata[`MODE_ALT_BIT];
      end
      if (reg_acc_i.rd) begin
         case (reg_acc_i.addr)
            `REG_IRQ_FLAGS: st_nxt.rd_data = st_r.flags;
            `REG_IRQ_MASK: st_nxt.rd_data = st_r.mask;
            `REG_MODE_CTRL: begin
               st_nxt.rd_data = 16'h0000;
               st_nxt.rd_data[`MODE_ALT_BIT] = st_r.alt;
               st_nxt.rd_data[`MODE_ENERGY_BIT] = status_i.energy_detect;
            end
            default: st_nxt.rd_data = 16'h0000;
         endcase
      end
      // late energy pulse; the delay timer only runs while the mask stays set
      case (st_r.ed)
         phy_irq_pkg::ED_IDLE: begin
            if (!st_r.alt && st_r.mask[`SRC_ENERGY] && cond[`SRC_ENERGY] &&
                st_r.flags[`SRC_ENERGY] && !st_nxt.flags[`SRC_ENERGY]) begin
               st_nxt.ed = phy_irq_pkg::ED_ARMED;
            end
         end
         phy_irq_pkg::ED_ARMED: begin
            if (!st_r.mask[`SRC_ENERGY]) begin
               st_nxt.ed = phy_irq_pkg::ED_IDLE;
            end else if (fall[`SRC_ENERGY]) begin
               st_nxt.ed = phy_irq_pkg::ED_WAIT;
               st_nxt.cnt = 28'h0000000;
            end
         end
         phy_irq_pkg::ED_WAIT: begin
            st_nxt.cnt = st_r.cnt + 28'h0000001;
            if (!st_r.mask[`SRC_ENERGY]) begin
               st_nxt.ed = phy_irq_pkg::ED_IDLE;
            end else if (st_r.cnt == 28'(ED_DELAY_CYC - 1)) begin
               st_nxt.ed = phy_irq_pkg::ED_PULSE;
               st_nxt.cnt = 28'h0000000;
            end
         end
         phy_irq_pkg::ED_PULSE: begin
            st_nxt.cnt = st_r.cnt + 28'h0000001;
            if (st_r.cnt == 28'(ED_PULSE_CYC - 1)) begin
               st_nxt.ed = phy_irq_pkg::ED_IDLE;
            end
         end
         default: st_nxt.ed = phy_irq_pkg::ED_IDLE;
      endcase
      st_nxt.irq_n = ~(|(st_nxt.flags & st_nxt.mask) ||
                       st_nxt.ed == phy_irq_pkg::ED_PULSE);
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r.flags <= `FLAGS_RST;
         st_r.mask <= `MASK_RST;
         st_r.alt <= 1'b0;
         st_r.prev <= `COND_RST;
         st_r.ed <= phy_irq_pkg::ED_IDLE;
         st_r.cnt <= 28'h0000000;
         st_r.rd_data <= 16'h0000;
         st_r.irq_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_o = st_r.rd_data;
   assign irq_out_n_o = st_r.irq_n;
   assign alt_irq_select_o = st_r.alt;

   localparam int DLY_LAST = ED_DELAY_CYC - 1;
   localparam int PLS_LAST = ED_PULSE_CYC - 1;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   logic wr_alt_one;
   assign wr_alt_one = reg_acc_i.wr &&
      reg_acc_i.addr == `REG_MODE_CTRL && reg_acc_i.wdata[`MODE_ALT_BIT];

   a_mode_stays_primary: assert property (
      !alt_irq_select_o && !wr_alt_one |=> !alt_irq_select_o)
      else $error("alternate mode entered without a write");

   a_alt_select_write: assert property (
      wr_alt_one |=> alt_irq_select_o)
      else $error("alternate select write not taken");

   a_event_asserts_irq: assert property (
      !st_r.alt && |(rise & st_r.mask) && !reg_acc_i.wr
      |=> !irq_out_n_o)
      else $error("masked event did not assert interrupt");

   a_flags_read_clear: assert property (
      !st_r.alt && rd_flags && rise == 16'h0000 |=> st_r.flags == 16'h0000)
      else $error("flags read did not clear flags");

   a_status_read_clear: assert property (
      !st_r.alt && reg_acc_i.rd && reg_acc_i.addr == `REG_BASIC_STATUS &&
      (rise & `LINK_CLR_BITS) == 16'h0000
      |=> (st_r.flags & `LINK_CLR_BITS) == 16'h0000)
      else $error("status read left link flags set");

   a_restart_clear: assert property (
      !st_r.alt && status_i.an_restart && (rise & `AN_CLR_BITS) == 16'h0000
      |=> (st_r.flags & `AN_CLR_BITS) == 16'h0000)
      else $error("an restart left an flags set");

   a_alt_flag_holds: assert property (
      st_r.alt && wr_flags && reg_acc_i.wdata[`SRC_ENERGY] &&
      status_i.energy_detect && st_r.flags[`SRC_ENERGY]
      |=> st_r.flags[`SRC_ENERGY])
      else $error("flag cleared while source active");

   a_alt_link_clear: assert property (
      st_r.alt && wr_flags && reg_acc_i.wdata[`SRC_LINK_DOWN] &&
      status_i.link_up && !rise[`SRC_LINK_DOWN]
      |=> !st_r.flags[`SRC_LINK_DOWN])
      else $error("link down flag not cleared with link up");

   a_mask_clear_release: assert property (
      st_r.alt && st_r.ed == phy_irq_pkg::ED_IDLE && reg_acc_i.wr &&
      reg_acc_i.addr == `REG_IRQ_MASK &&
      ((st_r.flags | rise) & reg_acc_i.wdata) == 16'h0000
      |=> irq_out_n_o)
      else $error("mask clear did not release interrupt");

   a_pulse_start: assert property (
      st_r.ed == phy_irq_pkg::ED_WAIT && st_r.mask[`SRC_ENERGY] &&
      st_r.cnt == 28'(DLY_LAST)
      |=> st_r.ed == phy_irq_pkg::ED_PULSE ##0 !irq_out_n_o)
      else $error("energy pulse did not start after delay");

   a_rfault_fall_clear: assert property (
      !st_r.alt && fall[`SRC_RFAULT] |=> !st_r.flags[`SRC_RFAULT])
      else $error("remote fault flag kept after its fall");

   a_an_done_fall: assert property (
      !st_r.alt && fall[`SRC_AN_DONE] |=> !st_r.flags[`SRC_AN_DONE])
      else $error("an done flag kept after its fall");

   a_wake_all_low: assert property (
      !st_r.alt && st_r.prev[`SRC_WAKE] && status_i.wake == 4'h0
      |=> !st_r.flags[`SRC_WAKE])
      else $error("wake flag kept with all wake bits low");

   a_link_loss_set: assert property (
      !status_i.link_up && !st_r.prev[`SRC_LINK_DOWN]
      |=> st_r.flags[`SRC_LINK_DOWN])
      else $error("link loss did not set link down flag");

   a_link_loss_clear: assert property (
      !st_r.alt && rise[`SRC_LINK_DOWN] &&
      (rise & `AN_CLR_BITS) == 16'h0000
      |=> (st_r.flags & `AN_CLR_BITS) == 16'h0000)
      else $error("link loss left an flags set");

   a_energy_rise_set: assert property (
      status_i.energy_detect && !st_r.prev[`SRC_ENERGY]
      |=> st_r.flags[`SRC_ENERGY])
      else $error("energy rise did not set its flag");

   a_flags_read_data: assert property (
      rd_flags |=> rd_data_o == $past(st_r.flags))
      else $error("flags read returned wrong data");

   a_mask_bits_kept: assert property (
      reg_acc_i.wr && reg_acc_i.addr == `REG_IRQ_MASK
      |=> st_r.mask == ($past(reg_acc_i.wdata) & `FLAG_BITS))
      else $error("mask write not stored in bits 8 to 1");

   a_mode_read_back: assert property (
      reg_acc_i.rd && reg_acc_i.addr == `REG_MODE_CTRL
      |=> rd_data_o[`MODE_ALT_BIT] == alt_irq_select_o)
      else $error("mode read does not show the select bit");

   a_alt_link_holds: assert property (
      st_r.alt && wr_flags && !status_i.link_up &&
      st_r.flags[`SRC_LINK_DOWN]
      |=> st_r.flags[`SRC_LINK_DOWN])
      else $error("link down flag cleared while link is down");

   a_alt_wake_clear: assert property (
      st_r.alt && wr_flags && reg_acc_i.wdata[`SRC_WAKE] &&
      status_i.wake == 4'h0
      |=> !st_r.flags[`SRC_WAKE])
      else $error("wake flag not cleared with all bits low");

   a_energy_arm: assert property (
      !st_r.alt && st_r.ed == phy_irq_pkg::ED_IDLE &&
      st_r.mask[`SRC_ENERGY] && rd_flags && st_r.flags[`SRC_ENERGY] &&
      st_r.prev[`SRC_ENERGY] && status_i.energy_detect
      |=> st_r.ed == phy_irq_pkg::ED_ARMED)
      else $error("energy release while high did not arm");

   a_delay_counts: assert property (
      st_r.ed == phy_irq_pkg::ED_WAIT && st_r.mask[`SRC_ENERGY] &&
      st_r.cnt < 28'(DLY_LAST)
      |=> st_r.ed == phy_irq_pkg::ED_WAIT)
      else $error("energy delay ended early");

   a_pulse_length: assert property (
      st_r.ed == phy_irq_pkg::ED_PULSE && st_r.cnt == 28'(PLS_LAST)
      |=> st_r.ed == phy_irq_pkg::ED_IDLE)
      else $error("energy pulse did not end on time");

   c_primary_event: cover property (
      !st_r.alt && |(rise & st_r.mask) ##1 !irq_out_n_o);
   c_alt_recheck: cover property (st_r.alt && wr_flags);
   c_energy_pulse: cover property (st_r.ed == phy_irq_pkg::ED_PULSE);
   c_alt_mask_release: cover property (
      st_r.alt && reg_acc_i.wr && reg_acc_i.addr == `REG_IRQ_MASK ##1
      irq_out_n_o);
   c_link_down_event: cover property (
      !st_r.alt && rise[`SRC_LINK_DOWN] ##1 !irq_out_n_o);

endmodule : phy_interrupt_manager

// ===== testbench/mgmt_ctrl.sv
`timescale 1ns/1ps
module mgmt_ctrl (
   input wire logic clk_sys_i,
   input wire logic [15:0] rd_data_i,
   output phy_irq_pkg::reg_acc_t acc_o
);
   initial acc_o = '0;
   // one strobe per access; address and data are inverted once released
   task automatic xfer(input logic w, input logic [4:0] a,
         input logic [15:0] d, output logic [15:0] q);
      @(negedge clk_sys_i);
      acc_o <= '{w, ~w, a, d};
      @(negedge clk_sys_i);
      acc_o <= '{1'b0, 1'b0, ~a, ~d};
      q = rd_data_i;
   endtask : xfer
   // service routine drops the energy mask so no late pulse follows
   task automatic isr_energy(input logic [15:0] m);
      logic [15:0] q;
      xfer(1'b1, 5'h1E, m & ~16'h0080, q);
   endtask : isr_energy
endmodule : mgmt_ctrl

// ===== testbench/phy_interrupt_manager_bench.sv
`timescale 1ns/1ps
module phy_interrupt_manager_bench;
   localparam int DLY = 20;
   localparam int PLS = 8;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   phy_irq_pkg::phy_status_t st = '0;
   phy_irq_pkg::reg_acc_t acc;
   logic [15:0] rd_data;
   logic [15:0] q;
   logic irq_n;
   logic alt;
   int err_total = 0;
   int n_tests = 0;
   int k;
   phy_interrupt_manager #(.ED_DELAY_CYC(DLY), .ED_PULSE_CYC(PLS)) DUT (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_acc_i(acc),
      .status_i(st), .rd_data_o(rd_data), .irq_out_n_o(irq_n),
      .alt_irq_select_o(alt));
   mgmt_ctrl u_mgr (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data),
      .acc_o(acc));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string s, input logic [15:0] e,
         input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : cyc
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      u_mgr.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [4:0] a);
      u_mgr.xfer(1'b0, a, 16'h0000, q);
   endtask : rd
   // two edges: the first sees and registers the event, the second is spare
   task automatic irq(input logic e);
      cyc(2);
      chk("irq_out_n", {15'h0000, e}, {15'h0000, irq_n});
   endtask : irq
   task automatic src(input int i, input logic a);
      case (i)
         8: st.wake = {3'h0, a};
         7: st.energy_detect = a;
         6: st.an_done = a;
         5: st.rfault = a;
         4: st.link_up = ~a;
         3: st.lp_ack = a;
         2: st.pdf = a;
         default: st.page = a;
      endcase
   endtask : src
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   initial begin
      cyc(20000);
      err_total++;
      report_and_stop();
   end
   initial begin
      st.energy_detect = 1'b1;
      st.link_up = 1'b1;
      cyc(16);
      sys_rst_i = 1'b0;
      chk("alt", 16'h0000, {15'h0000, alt});
      rd(5'h11);
      chk("mode", 16'h0002, q & 16'h0042);
      rd(5'h05);
      chk("unmapped", 16'h0000, q);
      wr(5'h1E, 16'h0080);
      irq(1'b0);
      src(7, 1'b0);
      irq(1'b1);
      for (k = 1; k <= 8; k++) begin
         if (k == 7) continue;
         wr(5'h1E, 16'h0001 << k);
         src(k, 1'b1);
         irq(1'b0);
         rd(5'h1D);
         chk("flags", 16'h0001 << k, q);
         irq(1'b1);
         src(k, 1'b0);
         cyc(2);
         src(k, 1'b1);
         irq(1'b0);
         src(k, 1'b0);
         irq(k == 4 ? 1'b0 : 1'b1);
         rd(5'h01);
         irq(1'b1);
      end
      wr(5'h1E, 16'h0080);
      src(7, 1'b1);
      irq(1'b0);
      rd(5'h1D);
      irq(1'b1);
      src(7, 1'b0);
      k = 0;
      while (irq_n === 1'b1 && k < 3 * DLY) begin
         cyc(1);
         k++;
      end
      chk("delay", 16'h0001, 16'(k >= DLY - 2 && k <= DLY + 3));
      k = 0;
      while (irq_n === 1'b0 && k < 3 * PLS) begin
         cyc(1);
         k++;
      end
      chk("pulse", 16'(PLS), 16'(k));
      src(7, 1'b1);
      irq(1'b0);
      u_mgr.isr_energy(16'h0080);
      irq(1'b1);
      src(7, 1'b0);
      wr(5'h1E, 16'h0006);
      for (k = 0; k < 3; k++) begin
         st.pdf = 1'b1;
         st.page = 1'b1;
         irq(1'b0);
         if (k == 0) rd(5'h06);
         else if (k == 1) st.an_restart = 1'b1;
         else st.link_up = 1'b0;
         cyc(1);
         st.an_restart = 1'b0;
         irq(1'b1);
         st.pdf = 1'b0;
         st.page = 1'b0;
         st.link_up = 1'b1;
         cyc(2);
      end
      rd(5'h1D);
      chk("flags", 16'h0010, q);
      wr(5'h11, 16'h0040);
      cyc(1);
      chk("alt", 16'h0001, {15'h0000, alt});
      wr(5'h1E, 16'hFFFF);
      rd(5'h1E);
      chk("mask", 16'h01FE, q);
      for (k = 1; k <= 8; k++) begin
         src(k, 1'b1);
         irq(1'b0);
         wr(5'h1D, 16'h0001 << k);
         irq(1'b0);
         src(k, 1'b0);
         irq(1'b0);
         wr(5'h1D, 16'h0001 << k);
         irq(1'b1);
         src(k, 1'b1);
         cyc(2);
         wr(5'h1E, 16'h01FE & ~(16'h0001 << k));
         irq(1'b1);
         src(k, 1'b0);
         wr(5'h1D, 16'h0001 << k);
         wr(5'h1E, 16'h01FE);
         irq(1'b1);
      end
      report_and_stop();
   end
endmodule : phy_interrupt_manager_bench
